// ### verilog/bsq_top.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`default_nettype none
// Function
// RULE1 - idle while squelch closed, busy otherwise; detection mode holds LINE_IDLE_O low
// RULE2 - supply noise never shows a busy line
// RULE3 - selectable detection or operating squelch mode
// RULE4 - send alternating bit stream, truncation allowed
// RULE5 - send until ready or vbus safe
// RULE6 - detect after 128 alternating bits
// RULE7 - stopped after squelch closed 1-3 ms; the stop timer runs in operating mode only
// RULE8 - stream bits bypass the symbol encoder
// RULE9 - synchronise squelch, timer restarts on open
module bsq_top #(
  parameter int MS_CYCLES     = bsq_pkg::MS_CYCLES,
  parameter int BUSY_FILT     = bsq_pkg::BUSY_FILT_CYCLES,
  parameter int TX_BIT_CYCLES = bsq_pkg::TX_BIT_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        SQUELCH_OPEN_I,
  input  wire logic        RX_BIT_I,
  input  wire logic        RX_BIT_VALID_I,
  input  wire logic        VBUS_SAFE0V_I,
  output logic             SQUELCH_MODE_O,
  output logic             LINE_IDLE_O,
  output logic             TX_BIT_O,
  output logic             TX_BIT_STROBE_O,
  output logic             TX_ACTIVE_O,
  output logic             STREAM_DETECTED_O,
  output logic             STREAM_STOPPED_O
);
  import bsq_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES);
  localparam int FW  = $clog2(BUSY_FILT + 1);
  localparam int TW  = $clog2(TX_BIT_CYCLES);
  localparam logic [MSW-1:0] MS_LAST  = MSW'(MS_CYCLES - 1);
  localparam logic [FW-1:0]  FILT_MAX = FW'(BUSY_FILT);
  localparam logic [TW-1:0]  TX_LAST  = TW'(TX_BIT_CYCLES - 1);

  if (MS_CYCLES < 2 || BUSY_FILT < 1 || TX_BIT_CYCLES < 2) begin : g_chk
    $error("bsq_top parameters out of range");
  end

  // ---------------- register bus ----------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        mode_det_q;
  logic        tx_en_q;
  logic        pd_ready_q;
  logic [1:0]  stop_ms_q;

  wire req      = AVS_READ_I | AVS_WRITE_I;
  wire take     = req & ~wait_q;
  wire wr_lane0 = take & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
  wire wr_ctrl  = wr_lane0 && (AVS_ADDRESS_I == CTRL_OFS);
  wire wr_stop  = wr_lane0 && (AVS_ADDRESS_I == STOPCFG_OFS);
  wire sw_clear = wr_ctrl & AVS_WRITEDATA_I[CTRL_CLR_BIT];
  wire [1:0] wr_ms = AVS_WRITEDATA_I[STOPCFG_LSB +: STOPCFG_W];
  // out-of-range timeouts are clamped so the interval stays inside 1..3 ms
  wire [1:0] stop_ms_d = (wr_ms < STOP_MS_MIN) ? STOP_MS_MIN : (wr_ms > STOP_MS_MAX) ? STOP_MS_MAX : wr_ms;  // RULE7

  logic det_flag_q;
  logic stop_flag_q;
  logic idle_q;
  logic tx_act_q;
  logic sq_sync_q;

  wire [31:0] ctrl_rd = {29'h0, pd_ready_q, tx_en_q, mode_det_q};
  wire [31:0] stat_rd = {27'h0, sq_sync_q, tx_act_q, stop_flag_q, det_flag_q, idle_q};
  wire [31:0] stop_rd = {30'h0, stop_ms_q};
  // unmapped addresses read zero and ignore writes
  wire [31:0] rd_mux  = (AVS_ADDRESS_I == CTRL_OFS)    ? ctrl_rd :
                        (AVS_ADDRESS_I == STATUS_OFS)  ? stat_rd :
                        (AVS_ADDRESS_I == STOPCFG_OFS) ? stop_rd : 32'h0;

  // one wait cycle per access, then the answer edge
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= AVS_READ_I ? rd_mux : 32'h0;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_det_q <= 1'b0;
      tx_en_q    <= 1'b0;
      pd_ready_q <= 1'b0;
      stop_ms_q  <= STOP_MS_RST;
    end else begin
      if (wr_ctrl) begin
        mode_det_q <= AVS_WRITEDATA_I[CTRL_MODE_BIT];  // RULE3
        tx_en_q    <= AVS_WRITEDATA_I[CTRL_TXEN_BIT];
        pd_ready_q <= AVS_WRITEDATA_I[CTRL_READY_BIT];
      end
      if (wr_stop) begin
        stop_ms_q  <= stop_ms_d;
      end
    end
  end

  // ---------------- squelch and idle ----------------
  logic          sq_meta_q;
  logic [FW-1:0] open_cnt_q;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sq_meta_q <= 1'b0;
      sq_sync_q <= 1'b0;
    end else begin
      sq_meta_q <= SQUELCH_OPEN_I;  // RULE9
      sq_sync_q <= sq_meta_q;
    end
  end

  // supply ripple gives short squelch blips; only a sustained opening means busy
  wire [FW-1:0] open_cnt_d = !sq_sync_q ? '0 : (open_cnt_q == FILT_MAX) ? FILT_MAX : open_cnt_q + FW'(1);  // RULE2
  wire busy_raw = (open_cnt_q == FILT_MAX);
  // in detection mode the comparator uses the lower threshold, so idle is withheld
  wire idle_d   = ~mode_det_q & ~busy_raw;  // RULE1

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      open_cnt_q <= '0;
      idle_q     <= 1'b1;
    end else begin
      open_cnt_q <= open_cnt_d;
      idle_q     <= idle_d;
    end
  end

  // ---------------- stream detect and stop timer ----------------
  bsq_det_if dif ();
  logic [MSW-1:0] ms_div_q;
  logic [1:0]     ms_cnt_q;

  wire ms_tick  = (ms_div_q == MS_LAST);
  wire timing   = det_flag_q & ~stop_flag_q & ~mode_det_q & ~sq_sync_q;
  wire stop_set = timing & ms_tick & (ms_cnt_q + 2'h1 == stop_ms_q);  // RULE7
  wire det_set  = dif.detected;

  assign dif.rx_bit   = RX_BIT_I;
  assign dif.rx_valid = RX_BIT_VALID_I;
  assign dif.clear    = sw_clear | stop_set;

  bsq_stream_det #(
    .MATCH_BITS (STREAM_MATCH_BITS)
  ) u_det (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .dif   (dif)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ms_div_q <= '0;
      ms_cnt_q <= 2'h0;
    end else if (!timing) begin
      ms_div_q <= '0;  // RULE9
      ms_cnt_q <= 2'h0;
    end else begin
      ms_div_q <= ms_tick ? '0 : ms_div_q + MSW'(1);
      ms_cnt_q <= ms_tick ? ms_cnt_q + 2'h1 : ms_cnt_q;
    end
  end

  // a hardware set in the same cycle as a software clear wins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      det_flag_q  <= 1'b0;
      stop_flag_q <= 1'b0;
    end else begin
      det_flag_q  <= det_set | (det_flag_q & ~sw_clear);  // RULE6
      stop_flag_q <= stop_set | (stop_flag_q & ~sw_clear);  // RULE7
    end
  end

  // ---------------- alternating stream transmitter ----------------
  bsq_tx_e       tx_st_q;
  bsq_tx_e       tx_st_d;
  logic [TW-1:0] tx_div_q;
  logic          tx_bit_q;
  logic          tx_stb_q;

  wire tx_go   = tx_en_q & ~pd_ready_q & ~VBUS_SAFE0V_I;  // RULE5
  wire tx_tick = (tx_div_q == TX_LAST);

  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      TX_IDLE: if (tx_go) begin
        tx_st_d = TX_RUN;
      end
      TX_RUN: if (!tx_go) begin
        tx_st_d = TX_DONE;  // RULE5
      end
      TX_DONE: if (!tx_en_q) begin
        tx_st_d = TX_IDLE;
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  // bits come straight from the toggle, no symbol coding; stopping mid-preamble is legal
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_st_q  <= TX_IDLE;
      tx_div_q <= '0;
      tx_bit_q <= 1'b1;
      tx_stb_q <= 1'b0;
      tx_act_q <= 1'b0;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_act_q <= (tx_st_d == TX_RUN);
      tx_div_q <= (tx_st_q != TX_RUN || tx_tick) ? '0 : tx_div_q + TW'(1);
      tx_stb_q <= (tx_st_q == TX_RUN) & tx_tick & tx_go;
      if (tx_st_q != TX_RUN) begin
        tx_bit_q <= 1'b1;
      end else if (tx_tick & tx_go) begin
        tx_bit_q <= ~tx_bit_q;  // RULE4 RULE8
      end
    end
  end

  always_comb begin
    AVS_READDATA_O    = rdata_q;
    AVS_WAITREQUEST_O = wait_q;
    SQUELCH_MODE_O    = mode_det_q;
    LINE_IDLE_O       = idle_q;
    TX_BIT_O          = tx_bit_q;
    TX_BIT_STROBE_O   = tx_stb_q;
    TX_ACTIVE_O       = tx_act_q;
    STREAM_DETECTED_O = det_flag_q;
    STREAM_STOPPED_O  = stop_flag_q;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic        last_bit_q;
  logic        seen_q;
  logic        par_q;
  logic [31:0] closed_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      last_bit_q <= 1'b0;
      seen_q     <= 1'b0;
      par_q      <= 1'b0;
      closed_q   <= 32'h0;
    end else begin
      seen_q     <= TX_ACTIVE_O & (seen_q | TX_BIT_STROBE_O);
      last_bit_q <= TX_BIT_STROBE_O ? TX_BIT_O : last_bit_q;
      par_q      <= !TX_ACTIVE_O ? 1'b0 : par_q ^ TX_BIT_STROBE_O;
      closed_q   <= !timing ? 32'h0 : closed_q + 32'h1;
    end
  end

  sequence closed_two;
    !mode_det_q && !sq_sync_q [*2];
  endsequence

  idle_when_closed_a: assert property (closed_two |=> LINE_IDLE_O)  // RULE1
    else $error("line not idle after squelch closed");
  busy_needs_open_a: assert property (  // RULE2
    $fell(LINE_IDLE_O) && $past(!mode_det_q) |-> $past(busy_raw) && $past(sq_sync_q, 2))
    else $error("busy shown without sustained squelch");
  mode_follows_write_a: assert property (  // RULE3
    wr_ctrl |=> SQUELCH_MODE_O == $past(AVS_WRITEDATA_I[CTRL_MODE_BIT]))
    else $error("squelch mode not taken from control write");
  stream_alternates_a: assert property (  // RULE4
    TX_BIT_STROBE_O && seen_q |-> TX_BIT_O != last_bit_q)
    else $error("stream bit did not alternate");
  tx_stops_a: assert property (  // RULE5
    tx_st_q == TX_RUN && !tx_go |=> !TX_ACTIVE_O ##1 !TX_BIT_STROBE_O)
    else $error("stream kept running after stop condition");
  stop_interval_a: assert property (  // RULE7
    $rose(STREAM_STOPPED_O) |-> $past(closed_q) + 32'h1 == 32'(MS_CYCLES) * 32'(stop_ms_q))
    else $error("stream stop reported at wrong closed time");
  raw_bit_order_a: assert property (  // RULE8
    TX_BIT_STROBE_O |-> TX_BIT_O == par_q)
    else $error("stream bit not taken straight from toggle");
  timer_restart_a: assert property (  // RULE9
    sq_sync_q |=> ms_div_q == '0 && ms_cnt_q == 2'h0)
    else $error("stop timer not restarted on squelch open");
endmodule
`default_nettype wire

// ### verilog/bsq_pkg.sv
`default_nettype none
package bsq_pkg;
  // register map, byte addresses, one 32-bit word each
  localparam logic [3:0] CTRL_OFS      = 4'h0;
  localparam logic [3:0] STATUS_OFS    = 4'h4;
  localparam logic [3:0] STOPCFG_OFS   = 4'h8;
  // control fields
  localparam int CTRL_MODE_BIT         = 0;
  localparam int CTRL_TXEN_BIT         = 1;
  localparam int CTRL_READY_BIT        = 2;
  localparam int CTRL_CLR_BIT          = 3;
  // status fields
  localparam int ST_IDLE_BIT           = 0;
  localparam int ST_DET_BIT            = 1;
  localparam int ST_STOP_BIT           = 2;
  localparam int ST_TXACT_BIT          = 3;
  localparam int ST_SQOPEN_BIT         = 4;
  // stop-timeout field, in whole milliseconds, legal 1..3
  localparam int STOPCFG_LSB           = 0;
  localparam int STOPCFG_W             = 2;
  localparam logic [1:0] STOP_MS_RST   = 2'h2;
  localparam logic [1:0] STOP_MS_MIN   = 2'h1;
  localparam logic [1:0] STOP_MS_MAX   = 2'h3;
  // timing
  localparam int CLK_MHZ               = 250;
  localparam int MS_TIME_US            = 1000;
  localparam int MS_CYCLES             = MS_TIME_US * CLK_MHZ;
  localparam int BUSY_FILT_CYCLES      = 16;
  localparam int TX_BIT_CYCLES         = 16;
  // stream pattern
  localparam int STREAM_MATCH_BITS     = 128;
  localparam int PREAMBLE_BITS         = 64;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_RUN  = 2'b01,
    TX_DONE = 2'b11
  } bsq_tx_e;
endpackage
`default_nettype wire

// ### verilog/bsq_det_if.sv
`default_nettype none
interface bsq_det_if;
  logic rx_bit;
  logic rx_valid;
  logic clear;
  logic detected;
  modport det (input rx_bit, input rx_valid, input clear, output detected);
  modport ctl (output rx_bit, output rx_valid, output clear, input detected);
endinterface
`default_nettype wire

// ### verilog/bsq_stream_det.sv
`default_nettype none
module bsq_stream_det #(
  parameter int MATCH_BITS = bsq_pkg::STREAM_MATCH_BITS
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  bsq_det_if.det      dif
);
  import bsq_pkg::*;
  localparam int CW = $clog2(MATCH_BITS + 1);
  localparam logic [CW-1:0] FULL = CW'(MATCH_BITS);

  if (MATCH_BITS < 2) begin : g_chk
    $error("match length too short");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          prev_q;

  // a repeated bit restarts the run with itself as first bit
  wire alt_ok = (cnt_q == '0) || (dif.rx_bit != prev_q);
  assign cnt_d = !alt_ok ? CW'(1) : (cnt_q == FULL) ? FULL : cnt_q + CW'(1);  // RULE6
  assign dif.detected = (cnt_q == FULL);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      prev_q <= 1'b0;
    end else if (dif.clear) begin
      cnt_q  <= '0;
    end else if (dif.rx_valid) begin
      cnt_q  <= cnt_d;
      prev_q <= dif.rx_bit;
    end
  end

  match_count_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RULE6
    $rose(dif.detected) |-> $past(cnt_q) == FULL - CW'(1) && $past(dif.rx_valid))
    else $error("stream detected before full run of alternating bits");
endmodule
`default_nettype wire

// ### sim/bsq_far_port.sv
`default_nettype none
module bsq_far_port (
  input  wire logic clk_i,
  output logic      sq_open_o,
  output logic      rx_bit_o,
  output logic      rx_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sq_open_o = 1'b0;
    rx_bit_o = 1'b1;
    rx_valid_o = 1'b0;
  end
  task automatic squelch(input logic v);
    @(posedge clk_i);
    sq_open_o <= v;
  endtask
  // squelch stays open after the stream; the caller closes it
  task automatic send(input int n, input logic b);
    @(posedge clk_i);
    sq_open_o <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_bit_o <= b ^ i[0];
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      // data flips between pulses so a stale bit never reads as good
      rx_bit_o <= ~(b ^ i[0]);
      rx_valid_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### sim/test_bsq_top.sv
`default_nettype none
module test_bsq_top;
  import bsq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 50;
  localparam int TB = 4;
  logic        clk, rst, rd, wr, wq, sq, rb, rv, safe, mode, idle, tb, ts, ta, det, stp;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdat;
  logic [31:0] rq[$];
  logic        tq[$];
  int          n_mismatch, comparisons, cyc, nstb, lst;
  integer      seed;
  bsq_top #(.MS_CYCLES(MS), .TX_BIT_CYCLES(TB)) i_dut (
    .CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
    .SQUELCH_OPEN_I(sq), .RX_BIT_I(rb), .RX_BIT_VALID_I(rv), .VBUS_SAFE0V_I(safe),
    .SQUELCH_MODE_O(mode), .LINE_IDLE_O(idle), .TX_BIT_O(tb), .TX_BIT_STROBE_O(ts),
    .TX_ACTIVE_O(ta), .STREAM_DETECTED_O(det), .STREAM_STOPPED_O(stp));
  bsq_far_port i_far (.clk_i(clk), .sq_open_o(sq), .rx_bit_o(rb), .rx_valid_o(rv));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // for reads d is the expected word, noted before the request goes out
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= w ? d : 32'($random(seed));
    wr <= w;
    rd <= ~w;
    if (!w) rq.push_back(d);
    do @(posedge clk); while (wq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  always @(posedge clk) if (rd && wq === 1'b0) chk_reg("readdata", rq.pop_front(), rdat);
  always @(posedge clk) if (ts === 1'b1) begin
    nstb++;
    if (tq.size() > 0) begin
      chk_pin("tx bit", tq.pop_front(), tb);
      if (nstb > 1) chk_reg("tx spacing", TB, cyc - lst);
    end
    lst = cyc;
  end
  initial begin
    seed = 32'h7e7baca4;
    cyc = 0;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    be = 4'hf;
    wd = 32'h0;
    safe = 1'b0;
    cy(6);
    rst <= 1'b0;
    bus(0, STATUS_OFS, 32'h1);
    bus(0, STOPCFG_OFS, 32'h2);
    bus(0, 4'hc, 32'h0);
    bus(1, CTRL_OFS, 32'h1);
    cy(2);
    chk_pin("squelch mode", 1'b1, mode);
    chk_pin("idle", 1'b0, idle);
    bus(1, CTRL_OFS, 32'h0);
    cy(2);
    chk_pin("squelch mode", 1'b0, mode);
    $display("test regs and modes done");
    // bursts shorter than the busy filter stand for supply noise
    repeat (6) begin
      i_far.squelch(1'b1);
      cy(1 + int'($unsigned($random(seed)) % 12));
      i_far.squelch(1'b0);
      cy(6);
      chk_pin("idle", 1'b1, idle);
    end
    i_far.squelch(1'b1);
    cy(24);
    chk_pin("idle", 1'b0, idle);
    i_far.squelch(1'b0);
    cy(6);
    chk_pin("idle", 1'b1, idle);
    $display("test idle done");
    bus(1, STOPCFG_OFS, 32'h0);
    bus(0, STOPCFG_OFS, 32'h1);
    // lane 0 disabled: the write must leave the timeout alone
    be <= 4'he;
    bus(1, STOPCFG_OFS, 32'h3);
    be <= 4'hf;
    bus(0, STOPCFG_OFS, 32'h1);
    i_far.send(127, 1'b0);
    cy(4);
    chk_pin("detected", 1'b0, det);
    i_far.send(128, 1'b0);
    cy(3);
    chk_pin("detected", 1'b1, det);
    i_far.squelch(1'b0);
    cy(30);
    i_far.squelch(1'b1);
    cy(2);
    i_far.squelch(1'b0);
    cy(45);
    chk_pin("stopped", 1'b0, stp);
    cy(20);
    chk_pin("stopped", 1'b1, stp);
    bus(1, CTRL_OFS, 32'h8);
    cy(1);
    chk_pin("detected", 1'b0, det);
    chk_pin("stopped", 1'b0, stp);
    $display("test stream receive done");
    for (int i = 0; i < 8; i++) tq.push_back(i[0]);
    nstb = 0;
    bus(1, CTRL_OFS, 32'h2);
    cy(2);
    chk_pin("tx active", 1'b1, ta);
    while (nstb < 8) @(posedge clk);
    bus(1, CTRL_OFS, 32'h6);
    cy(2);
    chk_pin("tx active", 1'b0, ta);
    nstb = 0;
    cy(20);
    chk_reg("late strobes", 32'h0, nstb);
    bus(1, CTRL_OFS, 32'h2);
    cy(2);
    chk_pin("tx active", 1'b0, ta);
    bus(1, CTRL_OFS, 32'h0);
    bus(1, CTRL_OFS, 32'h2);
    cy(2);
    chk_pin("tx active", 1'b1, ta);
    safe <= 1'b1;
    cy(3);
    chk_pin("tx active", 1'b0, ta);
    $display("test stream transmit done");
    summarize();
  end
endmodule
`default_nettype wire
